// ### design/obl_pkg.sv
/*
 * obl_pkg: shared constants, types and states for the option byte loader.
 * assumes: one 200 MHz system clock, flash read port on that clock,
 * ahb-lite register bus with 32-bit data.
 */
// Functional notes
// - reload option bytes on every reset source
// - hold processor until latches are loaded
// - option latches not reachable from software
// - flash changes apply only after next reset
// - bit7 picks watchdog interrupt or reset
// - watchdog interrupt taken only when enabled globally
// - bit6 zero keeps watchdog always running
// - bits5:4 pick oscillator drive mode
// - bit3 keeps brownout on in stop
// - bit2 zero blocks code read, limits debug
// - bit0 zero locks user program and erase
// - rc mode halves oscillator, crystal passes straight
package obl_pkg;

    // flash locations of the two option bytes
    localparam logic [15:0] FLASH_USER_ADDR = 16'h0000;
    localparam logic [15:0] FLASH_RSV_ADDR = 16'h0001;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // field positions inside the user option byte
    localparam int BIT_WDT_ACTION = 7;
    localparam int BIT_WDT_ALWAYS_ON = 6;
    localparam int BIT_OSC_HI = 5;
    localparam int BIT_OSC_LO = 4;
    localparam int BIT_BROWNOUT_KEEP = 3;
    localparam int BIT_READ_PROTECT = 2;
    localparam int BIT_RSV = 1;
    localparam int BIT_WRITE_LOCK = 0;

    // oscillator drive modes
    localparam logic [1:0] OSC_RC = 2'h0;
    localparam logic [1:0] OSC_LOW = 2'h1;
    localparam logic [1:0] OSC_MED = 2'h2;
    localparam logic [1:0] OSC_HIGH = 2'h3;

    // bus register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;

    // control register bits
    localparam int CTRL_GLOBAL_IE = 0;
    localparam int CTRL_STOP_MODE = 1;
    localparam int CTRL_WDT_ARM = 2;

    // status register bits
    localparam int STAT_LOAD_DONE = 0;
    localparam int STAT_WDT_RUN = 1;
    localparam int STAT_IRQ_PEND = 2;
    localparam int STAT_RSV_BAD = 3;

    // reset values and synchronised pin count
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int SYNC_STAGES = 3;

    // decoded option latches
    typedef struct packed {
        logic watchdog_timeout_action;
        logic watchdog_always_on;
        logic [1:0] oscillator_drive_select;
        logic brownout_keep_in_stop;
        logic code_read_protect;
        logic user_flash_write_lock;
    } obl_cfg_t;

    localparam obl_cfg_t CFG_ERASED = '{1'b1, 1'b1, 2'h3, 1'b1, 1'b1, 1'b1};

    // flash read request carrier
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } obl_flash_req_t;

    // loader sequence
    typedef enum logic [2:0] {
        LD_HOLD,
        LD_RD_USER,
        LD_WAIT_USER,
        LD_RD_RSV,
        LD_WAIT_RSV,
        LD_DONE
    } obl_ld_state_t;

endpackage

// ### design/obl_clk_div.sv
/*
 * obl_clk_div: system clock enable from the sampled oscillator input.
 * assumes: osc_level_i is already synchronised to clk_i.
 */
`timescale 1ns/1ps
module obl_clk_div (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_level_i,
    input wire logic rc_mode_i,
    output logic sys_clk_en_o,
    output logic sys_clk_o
);

    logic prev_reg, prev_next;
    logic div_reg, div_next;
    logic en_reg, en_next;
    logic clk_reg, clk_next;
    logic rise;

    // rising edge of the oscillator, halved in rc mode
    always_comb begin
        rise = osc_level_i & ~prev_reg;
        prev_next = osc_level_i;
        div_next = rise ? ~div_reg : div_reg;
        en_next = rc_mode_i ? (rise & ~div_reg) : rise;
        clk_next = rc_mode_i ? div_reg : osc_level_i;
    end

    // register stage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            div_reg <= 1'b0;
            en_reg <= 1'b0;
            clk_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            div_reg <= div_next;
            en_reg <= en_next;
            clk_reg <= clk_next;
        end
    end

    assign sys_clk_en_o = en_reg;
    assign sys_clk_o = clk_reg;

endmodule

// ### design/option_byte_loader.sv
/*
 * option_byte_loader: fetches the option bytes from flash after every
 * reset source and drives the hidden option latches to their users.
 * assumes: flash read port answers on the system clock with rvalid;
 * external reset, stop recovery and oscillator pins are asynchronous.
 */
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module option_byte_loader (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // pins from outside the clock domain
    input wire logic EXT_RESET_I,
    input wire logic STOP_RECOVERY_I,
    input wire logic OSC_INPUT_PIN_I,
    // flash read port
    output logic FLASH_RD_O,
    output logic [15:0] FLASH_ADDR_O,
    input wire logic [7:0] FLASH_RDATA_I,
    input wire logic FLASH_RVALID_I,
    // processor and watchdog
    output logic CPU_RELEASE_O,
    input wire logic WDT_TIMEOUT_I,
    input wire logic CPU_IRQ_ACK_I,
    output logic WDT_IRQ_O,
    output logic WDT_RESET_REQ_O,
    output logic WDT_RUN_O,
    // oscillator, brownout, debug, flash controller
    output logic [1:0] OSC_DRIVE_SELECT_O,
    output logic SYS_CLK_EN_O,
    output logic SYS_CLK_O,
    output logic BROWNOUT_EN_O,
    output logic CODE_READ_EN_O,
    output logic DEBUG_FULL_O,
    output logic USER_PROGRAM_EN_O,
    output logic USER_PAGE_ERASE_EN_O,
    output logic USER_MASS_ERASE_EN_O,
    output logic DEBUG_MASS_ERASE_EN_O,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);

    // pin synchronisers: bit0 external reset, bit1 stop recovery, bit2 osc
    logic [obl_pkg::SYNC_STAGES-1:0] pins;
    logic [obl_pkg::SYNC_STAGES-1:0] meta_reg, meta_next;
    logic [obl_pkg::SYNC_STAGES-1:0] sync_reg, sync_next;

    assign pins = {OSC_INPUT_PIN_I, STOP_RECOVERY_I, EXT_RESET_I};

    genvar gi;
    generate
        for (gi = 0; gi < obl_pkg::SYNC_STAGES; gi++) begin : g_sync
            // two flops per pin, only the second one is read
            always_comb begin
                meta_next[gi] = pins[gi];
                sync_next[gi] = meta_reg[gi];
            end

            always_ff @(posedge CLK_SYS_I) begin
                if (!RESET_N_I) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= meta_next[gi];
                    sync_reg[gi] <= sync_next[gi];
                end
            end
        end
    endgenerate

    logic ext_rst;
    logic stop_prev_reg, stop_prev_next;
    logic stop_rise;

    assign ext_rst = sync_reg[0];

    // stop recovery edge
    always_comb begin
        stop_prev_next = sync_reg[1];
        stop_rise = sync_reg[1] & ~stop_prev_reg;
    end

    // loader sequence state
    obl_pkg::obl_ld_state_t state_reg, state_next;
    logic [7:0] user_byte_reg, user_byte_next;
    obl_pkg::obl_cfg_t cfg_reg, cfg_next;
    logic rsv_bad_reg, rsv_bad_next;
    obl_pkg::obl_flash_req_t freq_reg, freq_next;
    logic reload;

    assign reload = ext_rst | stop_rise;

    // fetch byte zero then byte one, commit both at once
    always_comb begin
        state_next = state_reg;
        user_byte_next = user_byte_reg;
        cfg_next = cfg_reg;
        rsv_bad_next = rsv_bad_reg;
        freq_next = '0;
        freq_next.addr = freq_reg.addr;
        if (ext_rst) begin
            state_next = obl_pkg::LD_HOLD;
        end else if (stop_rise) begin
            state_next = obl_pkg::LD_RD_USER;
        end else begin
            case (state_reg)
                obl_pkg::LD_HOLD: begin
                    state_next = obl_pkg::LD_RD_USER;
                end
                obl_pkg::LD_RD_USER: begin
                    freq_next.rd = 1'b1;
                    freq_next.addr = obl_pkg::FLASH_USER_ADDR;
                    state_next = obl_pkg::LD_WAIT_USER;
                end
                obl_pkg::LD_WAIT_USER: begin
                    if (FLASH_RVALID_I) begin
                        user_byte_next = FLASH_RDATA_I;
                        state_next = obl_pkg::LD_RD_RSV;
                    end
                end
                obl_pkg::LD_RD_RSV: begin
                    freq_next.rd = 1'b1;
                    freq_next.addr = obl_pkg::FLASH_RSV_ADDR;
                    state_next = obl_pkg::LD_WAIT_RSV;
                end
                obl_pkg::LD_WAIT_RSV: begin
                    if (FLASH_RVALID_I) begin
                        // latches change only here, once per reset
                        cfg_next.watchdog_timeout_action =
                            user_byte_reg[obl_pkg::BIT_WDT_ACTION];
                        cfg_next.watchdog_always_on =
                            user_byte_reg[obl_pkg::BIT_WDT_ALWAYS_ON];
                        cfg_next.oscillator_drive_select =
                            user_byte_reg[obl_pkg::BIT_OSC_HI:obl_pkg::BIT_OSC_LO];
                        cfg_next.brownout_keep_in_stop =
                            user_byte_reg[obl_pkg::BIT_BROWNOUT_KEEP];
                        cfg_next.code_read_protect =
                            user_byte_reg[obl_pkg::BIT_READ_PROTECT];
                        cfg_next.user_flash_write_lock =
                            user_byte_reg[obl_pkg::BIT_WRITE_LOCK];
                        // reserved bits are only watched, never used
                        rsv_bad_next = (FLASH_RDATA_I != obl_pkg::ERASED_BYTE) |
                            ~user_byte_reg[obl_pkg::BIT_RSV];
                        state_next = obl_pkg::LD_DONE;
                    end
                end
                obl_pkg::LD_DONE: begin
                    state_next = obl_pkg::LD_DONE;
                end
                default: begin
                    state_next = obl_pkg::LD_HOLD;
                end
            endcase
        end
    end

    // loader registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            state_reg <= obl_pkg::LD_HOLD;
            user_byte_reg <= obl_pkg::ERASED_BYTE;
            cfg_reg <= obl_pkg::CFG_ERASED;
            rsv_bad_reg <= 1'b0;
            freq_reg <= '0;
            stop_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            user_byte_reg <= user_byte_next;
            cfg_reg <= cfg_next;
            rsv_bad_reg <= rsv_bad_next;
            freq_reg <= freq_next;
            stop_prev_reg <= stop_prev_next;
        end
    end

    logic loaded;
    assign loaded = (state_reg == obl_pkg::LD_DONE);

    // ahb-lite data phase capture
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic addr_ok;
    logic [31:0] status_word;

    // control state written by software
    logic global_ie_reg, global_ie_next;
    logic stop_mode_reg, stop_mode_next;
    logic armed_reg, armed_next;
    logic irq_pend_reg, irq_pend_next;
    logic wdt_rst_reg, wdt_rst_next;
    logic ctrl_wr;
    logic wdt_run;

    assign wdt_run = ~cfg_reg.watchdog_always_on | armed_reg;

    // status shows loader and watchdog state, never the latches
    always_comb begin
        status_word = '0;
        status_word[obl_pkg::STAT_LOAD_DONE] = loaded;
        status_word[obl_pkg::STAT_WDT_RUN] = wdt_run;
        status_word[obl_pkg::STAT_IRQ_PEND] = irq_pend_reg;
        status_word[obl_pkg::STAT_RSV_BAD] = rsv_bad_reg;
    end

    // address phase: take request, prepare read data
    always_comb begin
        addr_ok = HSEL & HREADY & HTRANS[1];
        wr_pend_next = addr_ok & HWRITE;
        wr_addr_next = addr_ok ? HADDR[7:0] : wr_addr_reg;
        rdata_next = rdata_reg;
        if (addr_ok & ~HWRITE) begin
            // option latches have no address at all
            case (HADDR[7:0])
                obl_pkg::REG_CTRL: begin
                    rdata_next = {29'h0, 1'b0, stop_mode_reg, global_ie_reg};
                end
                obl_pkg::REG_STATUS: begin
                    rdata_next = status_word;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // control register and watchdog event logic
    always_comb begin
        ctrl_wr = wr_pend_reg & (wr_addr_reg == obl_pkg::REG_CTRL);
        global_ie_next = global_ie_reg;
        stop_mode_next = stop_mode_reg;
        armed_next = armed_reg;
        if (ctrl_wr) begin
            global_ie_next = HWDATA[obl_pkg::CTRL_GLOBAL_IE];
            stop_mode_next = HWDATA[obl_pkg::CTRL_STOP_MODE];
            if (HWDATA[obl_pkg::CTRL_WDT_ARM] & loaded) begin
                armed_next = 1'b1;
            end
        end
        if (reload) begin
            // reset and stop recovery both disarm the watchdog
            armed_next = 1'b0;
            stop_mode_next = 1'b0;
        end
        irq_pend_next = irq_pend_reg;
        if (CPU_IRQ_ACK_I & global_ie_reg) begin
            irq_pend_next = 1'b0;
        end
        if (WDT_TIMEOUT_I & wdt_run & ~cfg_reg.watchdog_timeout_action) begin
            irq_pend_next = 1'b1;
        end
        wdt_rst_next = WDT_TIMEOUT_I & wdt_run & cfg_reg.watchdog_timeout_action;
    end

    // bus and control registers
    always_ff @(posedge CLK_SYS_I) begin
        if (!RESET_N_I) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg <= 32'h0000_0000;
            global_ie_reg <= obl_pkg::CTRL_RESET[obl_pkg::CTRL_GLOBAL_IE];
            stop_mode_reg <= obl_pkg::CTRL_RESET[obl_pkg::CTRL_STOP_MODE];
            armed_reg <= 1'b0;
            irq_pend_reg <= 1'b0;
            wdt_rst_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            global_ie_reg <= global_ie_next;
            stop_mode_reg <= stop_mode_next;
            armed_reg <= armed_next;
            irq_pend_reg <= irq_pend_next;
            wdt_rst_reg <= wdt_rst_next;
        end
    end

    // clock enable from the oscillator pin
    obl_clk_div u_clk_div (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .osc_level_i(sync_reg[2]),
        .rc_mode_i(cfg_reg.oscillator_drive_select == obl_pkg::OSC_RC),
        .sys_clk_en_o(SYS_CLK_EN_O),
        .sys_clk_o(SYS_CLK_O)
    );

    // bus answers: zero wait, always okay
    assign HRDATA = rdata_reg;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // flash read port
    assign FLASH_RD_O = freq_reg.rd;
    assign FLASH_ADDR_O = freq_reg.addr;

    // processor waits for the loader
    assign CPU_RELEASE_O = loaded;

    // watchdog users
    assign WDT_IRQ_O = irq_pend_reg & global_ie_reg;
    assign WDT_RESET_REQ_O = wdt_rst_reg;
    assign WDT_RUN_O = wdt_run;

    // option latch consumers
    assign OSC_DRIVE_SELECT_O = cfg_reg.oscillator_drive_select;
    assign BROWNOUT_EN_O = cfg_reg.brownout_keep_in_stop | ~stop_mode_reg;
    assign CODE_READ_EN_O = cfg_reg.code_read_protect;
    assign DEBUG_FULL_O = cfg_reg.code_read_protect;
    assign USER_PROGRAM_EN_O = cfg_reg.user_flash_write_lock;
    assign USER_PAGE_ERASE_EN_O = cfg_reg.user_flash_write_lock;
    assign USER_MASS_ERASE_EN_O = 1'b0; // user mass erase never offered
    assign DEBUG_MASS_ERASE_EN_O = 1'b1;

endmodule

// ### verif/obl_sva.sv
/*
 * obl_sva: concurrent checks on the option byte loader's top ports.
 * assumes: bound to option_byte_loader, one clock domain, sync reset.
 */
`timescale 1ns/1ps
module obl_sva (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic FLASH_RD_O,
    input wire logic [15:0] FLASH_ADDR_O,
    input wire logic FLASH_RVALID_I,
    input wire logic CPU_RELEASE_O,
    input wire logic WDT_TIMEOUT_I,
    input wire logic CPU_IRQ_ACK_I,
    input wire logic WDT_IRQ_O,
    input wire logic WDT_RESET_REQ_O,
    input wire logic WDT_RUN_O,
    input wire logic [1:0] OSC_DRIVE_SELECT_O,
    input wire logic SYS_CLK_EN_O,
    input wire logic CODE_READ_EN_O,
    input wire logic DEBUG_FULL_O,
    input wire logic USER_PROGRAM_EN_O,
    input wire logic USER_PAGE_ERASE_EN_O,
    input wire logic USER_MASS_ERASE_EN_O,
    input wire logic DEBUG_MASS_ERASE_EN_O
);
    // all checks on the system clock, quiet during reset
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESET_N_I);

    rel_after_fetch_a: assert property ($rose(CPU_RELEASE_O) |-> $past(FLASH_RVALID_I))
        else $error("release without a final flash answer");
    rd_while_held_a: assert property (FLASH_RD_O |-> !CPU_RELEASE_O)
        else $error("flash read while processor released");
    second_byte_a: assert property (FLASH_RVALID_I && !CPU_RELEASE_O &&
        FLASH_ADDR_O == 16'h0000 |-> ##2 FLASH_RD_O && FLASH_ADDR_O == 16'h0001)
        else $error("second option byte not fetched next");
    commit_release_a: assert property (FLASH_RVALID_I && !CPU_RELEASE_O &&
        FLASH_ADDR_O == 16'h0001 |=> CPU_RELEASE_O)
        else $error("processor not released after last byte");
    latch_steady_a: assert property (CPU_RELEASE_O && $past(CPU_RELEASE_O) |->
        $stable(OSC_DRIVE_SELECT_O) && $stable(CODE_READ_EN_O) && $stable(USER_PROGRAM_EN_O))
        else $error("option latch changed without reload");
    rc_halves_a: assert property (SYS_CLK_EN_O && OSC_DRIVE_SELECT_O == 2'h0 |=>
        !SYS_CLK_EN_O [*3])
        else $error("rc mode clock enable too dense");
    wdt_reset_a: assert property (WDT_RESET_REQ_O |-> $past(WDT_TIMEOUT_I) && $past(WDT_RUN_O))
        else $error("watchdog reset without running timeout");
    irq_ack_a: assert property (WDT_IRQ_O && CPU_IRQ_ACK_I && !WDT_TIMEOUT_I |->
        ##[1:2] !WDT_IRQ_O)
        else $error("acknowledged watchdog irq stays up");
    run_drop_a: assert property ($fell(WDT_RUN_O) |-> !CPU_RELEASE_O || !$past(CPU_RELEASE_O))
        else $error("watchdog stopped outside reload");
    debug_view_a: assert property (CODE_READ_EN_O == DEBUG_FULL_O)
        else $error("code read and debug level disagree");
    erase_set_a: assert property (USER_PROGRAM_EN_O == USER_PAGE_ERASE_EN_O &&
        !USER_MASS_ERASE_EN_O && DEBUG_MASS_ERASE_EN_O)
        else $error("program and erase enables inconsistent");
endmodule

bind option_byte_loader obl_sva chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
    .FLASH_RD_O(FLASH_RD_O), .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_RVALID_I(FLASH_RVALID_I),
    .CPU_RELEASE_O(CPU_RELEASE_O), .WDT_TIMEOUT_I(WDT_TIMEOUT_I), .CPU_IRQ_ACK_I(CPU_IRQ_ACK_I),
    .WDT_IRQ_O(WDT_IRQ_O), .WDT_RESET_REQ_O(WDT_RESET_REQ_O), .WDT_RUN_O(WDT_RUN_O),
    .OSC_DRIVE_SELECT_O(OSC_DRIVE_SELECT_O), .SYS_CLK_EN_O(SYS_CLK_EN_O),
    .CODE_READ_EN_O(CODE_READ_EN_O), .DEBUG_FULL_O(DEBUG_FULL_O),
    .USER_PROGRAM_EN_O(USER_PROGRAM_EN_O), .USER_PAGE_ERASE_EN_O(USER_PAGE_ERASE_EN_O),
    .USER_MASS_ERASE_EN_O(USER_MASS_ERASE_EN_O), .DEBUG_MASS_ERASE_EN_O(DEBUG_MASS_ERASE_EN_O));

// ### verif/obl_flash_model.sv
/*
 * obl_flash_model: behavioural flash read port holding the two option bytes.
 * assumes: one-cycle read pulse on the system clock, latency set by the bench.
 */
`timescale 1ns/1ps
module obl_flash_model (
    input wire logic clk_i,
    input wire logic rd_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] byte0_i,
    input wire logic [7:0] byte1_i,
    input wire logic [3:0] lat_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o
);
    int cnt = -1;
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] last = 8'h00;

    // quiet outputs before the first clock
    initial begin
        rvalid_o = 1'b0;
        rdata_o = 8'h00;
    end

    // one answer per read pulse, after lat_i+1 idle cycles
    always @(posedge clk_i) begin
        rvalid_o <= 1'b0;
        rdata_o <= ~last; // released data shows no stale byte
        if (rd_i) begin
            cnt <= lat_i;
            addr_q <= addr_i;
        end else if (cnt == 0) begin
            rvalid_o <= 1'b1;
            rdata_o <= (addr_q == 16'h0000) ? byte0_i : byte1_i;
            last <= (addr_q == 16'h0000) ? byte0_i : byte1_i;
            cnt <= -1;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ### verif/option_byte_loader_bench.sv
/*
 * option_byte_loader_bench: self-checking bench for the option byte loader.
 * assumes: obl_flash_model as flash partner, obl_sva bound to the design.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("FAIL %s exp %0h got %0h", nm, ex, gt); end end
module option_byte_loader_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ext_rst = 1'b0, stop_rec = 1'b0, osc = 1'b0, tmo = 1'b0, ack = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
    logic [7:0] b0 = 8'hff, b1 = 8'hff, frd;
    logic [3:0] lat = 4'h4;
    logic [15:0] fad;
    logic [1:0] osel;
    logic frq, fval, rel, irq, wrst, run, clk_en, sclk, bo, cre, dfull, upe, upg, ume, dme;
    logic hrdy, hresp;
    int error_cnt = 0, n_checks = 0, seed = 33, cyc = 0, en_cnt = 0, rst_cnt = 0, eb, i, k;
    int sc_cnt = 0;
    logic sclk_q = 1'b0;

    // 200 MHz system clock
    always #2.5 clk = ~clk;

    option_byte_loader dut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .EXT_RESET_I(ext_rst),
        .STOP_RECOVERY_I(stop_rec), .OSC_INPUT_PIN_I(osc), .FLASH_RD_O(frq), .FLASH_ADDR_O(fad),
        .FLASH_RDATA_I(frd), .FLASH_RVALID_I(fval), .CPU_RELEASE_O(rel), .WDT_TIMEOUT_I(tmo),
        .CPU_IRQ_ACK_I(ack), .WDT_IRQ_O(irq), .WDT_RESET_REQ_O(wrst), .WDT_RUN_O(run),
        .OSC_DRIVE_SELECT_O(osel), .SYS_CLK_EN_O(clk_en), .SYS_CLK_O(sclk), .BROWNOUT_EN_O(bo),
        .CODE_READ_EN_O(cre), .DEBUG_FULL_O(dfull), .USER_PROGRAM_EN_O(upe),
        .USER_PAGE_ERASE_EN_O(upg), .USER_MASS_ERASE_EN_O(ume), .DEBUG_MASS_ERASE_EN_O(dme),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp));

    obl_flash_model fl (.clk_i(clk), .rd_i(frq), .addr_i(fad), .byte0_i(b0), .byte1_i(b1),
        .lat_i(lat), .rdata_o(frd), .rvalid_o(fval));

    // cycle ceiling and output pulse counters
    always @(posedge clk) begin
        cyc++;
        if (clk_en === 1'b1) en_cnt++;
        if (sclk === 1'b1 && sclk_q !== 1'b1) sc_cnt++;
        sclk_q = sclk;
        if (wrst === 1'b1) rst_cnt++;
        if (cyc == 50000) begin
            error_cnt++;
            test_done();
        end
    end

    function automatic logic bt(int v, int n);
        return ((v >> n) & 1) != 0;
    endfunction

    task test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one ahb-lite single word transfer, read data left in rd
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
        `CHK("okay", 1'b0, hresp)
    endtask

    // wait for the loader to let the processor go
    task wait_rel();
        for (k = 0; k < 300 && rel !== 1'b1; k++) @(posedge clk);
        `CHK("release", 1'b1, rel)
    endtask

    // option outputs against the model byte eb
    task check_opts();
        `CHK("osc", 2'((eb >> 4) & 3), osel)
        `CHK("code_read", bt(eb, 2), cre)
        `CHK("debug_full", bt(eb, 2), dfull)
        `CHK("program", bt(eb, 0), upe)
        `CHK("page_erase", bt(eb, 0), upg)
        `CHK("mass_user", 1'b0, ume)
        `CHK("mass_debug", 1'b1, dme)
        `CHK("brownout", 1'b1, bo)
        `CHK("wdt_run", !bt(eb, 6), run)
    endtask

    // registers, oscillator, stop mode and watchdog for the loaded byte
    task run_checks();
        bus(1'b0, 32'h0000_0004, 32'h0000_0000);
        `CHK("status", {1'b0, 1'b0, !bt(eb, 6), 1'b1}, rd[3:0])
        bus(1'b1, 32'h0000_000c, 32'($random(seed)));
        bus(1'b0, 32'h0000_000c, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        bus(1'b0, 32'h0000_0000, 32'h0000_0000);
        `CHK("ctrl", 32'h0000_0000, rd)
        en_cnt = 0;
        sc_cnt = 0;
        for (k = 0; k < 16; k++) begin
            repeat (3) @(posedge clk);
            osc <= ~osc;
        end
        repeat (8) @(posedge clk);
        `CHK("clk_en", (((eb >> 4) & 3) == 0) ? 4 : 8, en_cnt)
        `CHK("sys_clk", (((eb >> 4) & 3) == 0) ? 4 : 8, sc_cnt)
        bus(1'b1, 32'h0000_0000, 32'h0000_0002);
        repeat (2) @(posedge clk);
        `CHK("brownout_stop", bt(eb, 3), bo)
        bus(1'b1, 32'h0000_0000, 32'h0000_0004);
        repeat (2) @(posedge clk);
        `CHK("wdt_armed", 1'b1, run)
        rst_cnt = 0;
        tmo <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("wdt_reset", bt(eb, 7) ? 1 : 0, rst_cnt)
        `CHK("irq_masked", 1'b0, irq)
        bus(1'b1, 32'h0000_0000, 32'h0000_0001);
        repeat (2) @(posedge clk);
        `CHK("irq", !bt(eb, 7), irq)
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("irq_ack", 1'b0, irq)
        bus(1'b1, 32'h0000_0000, 32'h0000_0000);
    endtask

    // reset, then reload by stop recovery and external reset in turn
    initial begin
        b0 = (8'($random(seed)) & 8'hfd) | 8'h02;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        eb = b0;
        wait_rel();
        check_opts();
        for (i = 0; i < 8; i++) begin
            run_checks();
            b0 <= (8'($random(seed)) & 8'hcd) | 8'((i % 4) << 4) | 8'h02;
            lat <= 4'(4 + ($random(seed) & 7));
            repeat (10) @(posedge clk);
            `CHK("kept", 2'((eb >> 4) & 3), osel)
            if (i % 2) ext_rst <= 1'b1;
            else stop_rec <= 1'b1;
            repeat (6) @(posedge clk);
            `CHK("held", 1'b0, rel)
            `CHK("kept_load", 2'((eb >> 4) & 3), osel)
            ext_rst <= 1'b0;
            stop_rec <= 1'b0;
            eb = b0;
            wait_rel();
            check_opts();
        end
        run_checks();
        test_done();
    end
endmodule
